//--- wdtg_guard.v
// Watchdog timer guard with APB register access and internal reset request
`timescale 1ns/100ps
// Function
// - Mode register accepts one byte write after reset
// - Second mode write requests internal reset
// - Reset request waits for running source clock
// - Mode register refuses partial byte writes
// - Unstoppable option ignores top mode bits
// - Stop bit halts stoppable watchdog forever, no reset
// - Wrong key write requests internal reset
// - Key register reads back fixed value
// - Mode write adds one bus wait cycle
// - Unstoppable option counts even in STOP
// - Unstoppable overflow in STOP requests reset
// - Stoppable option pauses in HALT and STOP
// - Resume uses clock selection set before
// - Stoppable option counter keeps its value across HALT/STOP
`include "wdtg_regs.vh"

module wdtg_guard (
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`WDTG_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire osc_unstoppable,
   input wire cpu_halt,
   input wire cpu_stop,
   output reg wdt_reset,
   output wire irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Option strap and bus decode

   reg strap_taken;
   reg unstop;
   reg [7:0] mode;
   reg mode_done;
   reg halted;
   reg rst_pending;
   reg wait_done;
   reg [`WDTG_ST_W-1:0] status;
   reg [`WDTG_ST_W-1:0] mask;
   reg [`WDTG_CNT_W-1:0] count;
   reg [`WDTG_DIV_W-1:0] div;
   reg osc_tick;

   wire access;
   wire wr;
   wire rd;
   wire sel_mode;
   wire sel_key;
   wire sel_status;
   wire sel_mask;
   wire sel_count;
   wire mapped;
   wire mode_wr;
   wire mode_wr_bad;
   wire key_wr;
   wire key_good;
   wire key_bad;
   wire src_running;
   wire [2:0] clk_sel;
   wire [`WDTG_CNT_W-1:0] limit;
   wire overflow;
   wire reset_event;
   wire [`WDTG_ST_W-1:0] st_set;
   wire [7:0] mode_in;

   // Strap is sampled once by a clocked process after release, never by the reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_taken <= 1'b0;
         unstop <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         unstop <= osc_unstoppable;
      end
   end

   assign access = psel & penable;
   assign sel_mode = (paddr == `WDTG_OFS_MODE);
   assign sel_key = (paddr == `WDTG_OFS_KEY);
   assign sel_status = (paddr == `WDTG_OFS_STATUS);
   assign sel_mask = (paddr == `WDTG_OFS_MASK);
   assign sel_count = (paddr == `WDTG_OFS_COUNT);
   assign mapped = sel_mode | sel_key | sel_status | sel_mask | sel_count;

   // Mode writes stretch the access by one cycle
   assign pready = ~(access & pwrite & sel_mode & ~wait_done);
   assign wr = access & pready & pwrite;
   assign rd = access & pready & ~pwrite;
   assign pslverr = access & pready & (~mapped | mode_wr_bad);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_done <= 1'b0;
      end else begin
         wait_done <= access & ~pready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode register

   // A write without the low byte lane is a partial write and never lands
   assign mode_wr_bad = pwrite & sel_mode & ~pstrb[0];
   assign mode_wr = wr & sel_mode & pstrb[0];

   // Top bits are forced to the required pattern when the option is set
   assign mode_in = unstop ?
      {`WDTG_MODE_TOP_VAL, pwdata[`WDTG_MODE_STOP_BIT:0]} : pwdata[7:0];

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode <= `WDTG_MODE_RST;
         mode_done <= 1'b0;
      end else if (mode_wr && !mode_done) begin
         mode <= mode_in;
         mode_done <= 1'b1;
      end
   end

   assign clk_sel = mode[`WDTG_MODE_SEL_HI:`WDTG_MODE_SEL_LO];

   // Once stopped the watchdog never restarts, clearing the bit has no effect
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         halted <= 1'b0;
      end else if (!unstop && mode[`WDTG_MODE_STOP_BIT]) begin
         halted <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key register

   assign key_wr = wr & sel_key;
   assign key_good = key_wr & (pwdata[7:0] == `WDTG_KEY_CLEAR);
   assign key_bad = key_wr & (pwdata[7:0] != `WDTG_KEY_CLEAR);

   ////////////////////////////////////////////////////////////////////////////
   // Source clock and counter

   // Unstoppable: always running; stoppable: paused in HALT/STOP, dead after stop bit
   assign src_running = unstop | (~halted & ~cpu_halt & ~cpu_stop);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div <= {`WDTG_DIV_W{1'b0}};
         osc_tick <= 1'b0;
      end else if (div == `WDTG_OSC_DIV - 1) begin
         div <= {`WDTG_DIV_W{1'b0}};
         osc_tick <= src_running;
      end else begin
         div <= div + 1'b1;
         osc_tick <= 1'b0;
      end
   end

   assign limit = {{(`WDTG_CNT_W-1){1'b0}}, 1'b1} << (`WDTG_OVF_BASE + clk_sel);
   assign overflow = osc_tick & src_running & (count == limit - 1'b1);

   // Counter only advances on ticks, so a pause keeps its value
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= {`WDTG_CNT_W{1'b0}};
      end else if (key_good) begin
         count <= {`WDTG_CNT_W{1'b0}};
      end else if (overflow) begin
         count <= {`WDTG_CNT_W{1'b0}};
      end else if (osc_tick && src_running) begin
         count <= count + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Internal reset request

   assign reset_event = key_bad | (mode_wr & mode_done) | overflow;

   // A request made while the source is stopped waits for it to run again
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_pending <= 1'b0;
         wdt_reset <= 1'b0;
      end else begin
         wdt_reset <= 1'b0;
         if ((reset_event || rst_pending) && src_running) begin
            rst_pending <= 1'b0;
            wdt_reset <= 1'b1;
         end else if (reset_event) begin
            rst_pending <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt

   assign st_set[`WDTG_ST_OVF] = overflow;
   assign st_set[`WDTG_ST_BADKEY] = key_bad;
   assign st_set[`WDTG_ST_REWRITE] = mode_wr & mode_done;
   assign st_set[`WDTG_ST_CLEARED] = key_good;

   // Read clears, but an event in the same cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < `WDTG_ST_W; gi = gi + 1) begin : g_st
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               status[gi] <= 1'b0;
            end else if (st_set[gi]) begin
               status[gi] <= 1'b1;
            end else if (rd && sel_status) begin
               status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask <= `WDTG_MASK_RST;
      end else if (wr && sel_mask) begin
         mask <= pwdata[`WDTG_ST_W-1:0];
      end
   end

   assign irq = |(status & mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (sel_mode) begin
            prdata <= {24'h000000, mode};
         end else if (sel_key) begin
            prdata <= {24'h000000, `WDTG_KEY_READ};
         end else if (sel_status) begin
            prdata <= {28'h0000000, status};
         end else if (sel_mask) begin
            prdata <= {28'h0000000, mask};
         end else if (sel_count) begin
            prdata <= {14'h0000, count};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

//--- wdtg_regs.vh
// Register map, field positions and timing constants of the watchdog guard
`ifndef WDTG_REGS_VH
`define WDTG_REGS_VH

`define WDTG_ADDR_W 12
`define WDTG_OFS_MODE 12'h000
`define WDTG_OFS_KEY 12'h004
`define WDTG_OFS_STATUS 12'h008
`define WDTG_OFS_MASK 12'h00C
`define WDTG_OFS_COUNT 12'h010

`define WDTG_MODE_RST 8'h67
`define WDTG_MODE_TOP_HI 7
`define WDTG_MODE_TOP_LO 5
`define WDTG_MODE_TOP_VAL 3'h3
`define WDTG_MODE_STOP_BIT 4
`define WDTG_MODE_SEL_HI 2
`define WDTG_MODE_SEL_LO 0

`define WDTG_KEY_CLEAR 8'hAC
`define WDTG_KEY_READ 8'h9A

`define WDTG_ST_W 4
`define WDTG_ST_OVF 0
`define WDTG_ST_BADKEY 1
`define WDTG_ST_REWRITE 2
`define WDTG_ST_CLEARED 3
`define WDTG_MASK_RST 4'h0

`define WDTG_CNT_W 18
`define WDTG_OVF_BASE 10

// Oscillator tick period in ns, and the clock period in ns
`define WDTG_OSC_NS 4000
`define WDTG_CLK_NS 100
`define WDTG_OSC_DIV ((`WDTG_OSC_NS) / (`WDTG_CLK_NS))
`define WDTG_DIV_W 6

`endif

//--- wdtg_guard_checker.sv
// Port assertions for the watchdog guard
`timescale 1ns/100ps
module wdtg_guard_checker (
   input logic clk,
   input logic nrst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic osc_unstoppable,
   input logic cpu_halt,
   input logic cpu_stop,
   input logic wdt_reset,
   input logic irq
);
   wire tk = psel && penable && pready && pwrite;
   wire mw = tk && paddr == 12'h000 && pstrb[0];
   wire kw = tk && paddr == 12'h004;
   reg done;
   // Tracks the single allowed mode write since reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
      end else if (mw) begin
         done <= 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   AST_WAIT: assert property (psel && $rose(penable) && pwrite && paddr == 12'h000 |-> !pready)
      else $error("mode write had no wait");
   AST_WAIT_END: assert property (psel && penable && pwrite && paddr == 12'h000 && !pready |=> pready)
      else $error("mode write wait too long");
   AST_KEY_READ: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata == 32'h9A)
      else $error("key read value wrong");
   AST_BAD_KEY: assert property (osc_unstoppable && kw && pwdata[7:0] != 8'hAC |=> wdt_reset)
      else $error("bad key gave no reset");
   AST_GOOD_KEY: assert property (kw && pwdata[7:0] == 8'hAC |=> !wdt_reset)
      else $error("good key gave reset");
   AST_FIRST: assert property (mw && !done |=> !wdt_reset)
      else $error("first mode write gave reset");
   AST_SECOND: assert property (osc_unstoppable && mw && done |=> wdt_reset)
      else $error("second mode write gave no reset");
   AST_HALTED: assert property (!osc_unstoppable && $past(cpu_halt || cpu_stop) |-> !wdt_reset)
      else $error("reset while source clock stopped");
   AST_PART: assert property (tk && paddr == 12'h000 && !pstrb[0] |-> pslverr)
      else $error("partial mode write not refused");
endmodule
bind wdtg_guard wdtg_guard_checker u_chk (.*);

//--- watchdog_timer_guard_test.sv
// Directed APB test of the watchdog guard
`timescale 1ns/100ps
module watchdog_timer_guard_test;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic osc_unstoppable = 1, cpu_halt = 0, cpu_stop = 0;
   logic pready, pslverr, wdt_reset, irq, er;
   int n_errors = 0, samples_checked = 0, nrs = 0, c1, k;
   wdtg_guard dut (.*);
   always #50 clk = ~clk;
   always @(posedge clk) if (wdt_reset === 1'b1) nrs <= nrs + 1;
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         samples_checked++;
         if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Idle cycle first, so a release never meets a new setup in one step
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int j;
      begin
         j = 0;
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         pstrb <= s;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         // Answer and data are taken at the rising edge that sees pready high, or after 9 wait cycles without it
         while (pready !== 1'b1 && j < 9) begin
            j++;
            @(posedge clk);
         end
         if (pready !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      begin
         xfer(1'b0, a, 32'h0, 4'h0);
         chk(rd, e);
      end
   endtask
   task rst(input logic u);
      begin
         @(posedge clk);
         nrst <= 1'b0;
         osc_unstoppable <= u;
         repeat (12) @(posedge clk);
         nrst <= 1'b1;
         repeat (2) @(posedge clk);
      end
   endtask
   task results;
      begin
         $display("errors=%0d checks=%0d", n_errors, samples_checked);
         if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      #9000000;
      n_errors++;
      results;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rst(1'b1);
      rdc(12'h004, 32'h9A);
      xfer(1'b1, 12'h000, 32'h0, 4'h0);
      chk(er, 32'h1);
      rdc(12'h000, 32'h67);
      xfer(1'b1, 12'h000, 32'h80, 4'hF);
      rdc(12'h000, 32'h60);
      xfer(1'b1, 12'h00C, 32'hF, 4'hF);
      xfer(1'b1, 12'h004, 32'hAC, 4'hF);
      rdc(12'h010, 32'h0);
      chk(nrs, 32'h0);
      xfer(1'b1, 12'h004, 32'h55, 4'hF);
      repeat (3) @(negedge clk);
      chk(nrs, 32'h1);
      chk(irq, 32'h1);
      rdc(12'h008, 32'hA);
      @(negedge clk);
      chk(irq, 32'h0);
      xfer(1'b1, 12'h000, 32'h60, 4'hF);
      repeat (3) @(negedge clk);
      chk(nrs, 32'h2);
      rdc(12'h020, 32'h0);
      chk(er, 32'h1);
      @(posedge clk);
      cpu_stop <= 1'b1;
      // Full 1024-tick interval at 40 clocks per tick
      k = 0;
      while (nrs < 3 && k < 42000) begin
         k++;
         @(negedge clk);
      end
      chk(nrs, 32'h3);
      chk(k > 40000, 32'h1);
      @(posedge clk);
      cpu_stop <= 1'b0;
      rst(1'b0);
      xfer(1'b1, 12'h000, 32'h60, 4'hF);
      repeat (400) @(posedge clk);
      cpu_halt <= 1'b1;
      xfer(1'b0, 12'h010, 32'h0, 4'h0);
      c1 = rd;
      rdc(12'h010, c1);
      repeat (400) @(posedge clk);
      rdc(12'h010, c1);
      cpu_halt <= 1'b0;
      repeat (400) @(posedge clk);
      xfer(1'b0, 12'h010, 32'h0, 4'h0);
      chk(rd > c1 + 8, 32'h1);
      cpu_stop <= 1'b1;
      xfer(1'b1, 12'h004, 32'h12, 4'hF);
      repeat (50) @(posedge clk);
      chk(nrs, 32'h3);
      cpu_stop <= 1'b0;
      repeat (3) @(negedge clk);
      chk(nrs, 32'h4);
      rst(1'b0);
      xfer(1'b1, 12'h000, 32'h70, 4'hF);
      xfer(1'b1, 12'h004, 32'h12, 4'hF);
      repeat (50) @(negedge clk);
      chk(nrs, 32'h4);
      results;
   end
endmodule
